// >>> core/caps_pkg.sv
// constants for the auxiliary pin function selector
// assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus
package caps_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] OFS_STORE = 4'h0;
  localparam logic [3:0] OFS_APPLY = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 4;
  localparam int CHG_SLEEP_BIT = 8;
  localparam int ST_BUSPWR_BIT = 9;
  localparam int ST_SUSP_BIT = 10;
  localparam int ST_FRAME_BIT = 11;
  localparam int APPLY_BIT = 0;
  // ****************************************
  // functions and reset values
  // ****************************************
  typedef enum logic [3:0] {
    FN_HIZ = 4'b0000,
    FN_DRIVE_HI = 4'b0001,
    FN_DRIVE_LO = 4'b0010,
    FN_POWER_SW = 4'b0011,
    FN_SLEEP_N = 4'b0100,
    FN_CLK24 = 4'b0101,
    FN_CLK12 = 4'b0110,
    FN_CLK6 = 4'b0111,
    FN_CHARGER = 4'b1000,
    FN_CHARGER_N = 4'b1001,
    FN_WR_STROBE_N = 4'b1010,
    FN_RD_STROBE_N = 4'b1011,
    FN_BUS_SENSE = 4'b1100,
    FN_FRAME_TGL = 4'b1101,
    FN_STAY_AWAKE_N = 4'b1110
  } caps_fn_e;
  localparam caps_fn_e RST_SEL_A = FN_BUS_SENSE;
  localparam caps_fn_e RST_SEL_B = FN_STAY_AWAKE_N;
  localparam logic RST_CHG_SLEEP = 1'b0;
  // ****************************************
  // clock output rates in MHz and axi response codes
  // ****************************************
  localparam int CLK_OUT_HI_MHZ = 24;
  localparam int CLK_OUT_MID_MHZ = 12;
  localparam int CLK_OUT_LO_MHZ = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : caps_pkg

// >>> core/caps_top.sv
// auxiliary pin function selector with its configuration store
// assumes device-side inputs on aclk and pins from outside
`timescale 1ns/1ps
module caps_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // usb engine state, same clock
  input wire logic usb_configured,
  input wire logic usb_suspend_req,
  input wire logic charger_port,
  input wire logic sof_pulse,
  input wire logic [2:0] clk_src,
  input wire logic pin_mode_write_strobe_n,
  input wire logic pin_mode_read_strobe_n,
  // usb engine results
  output logic bus_power_detect,
  output logic suspend_active,
  // aux pins, bit 0 is aux_pin_a, bit 1 is aux_pin_b
  input wire logic [1:0] aux_pin_in,
  output logic [1:0] aux_pin_out,
  output logic [1:0] aux_pin_oe,
  // fifo data port
  input wire logic [7:0] fifo_data_in,
  output logic [7:0] fifo_data_out,
  output logic [7:0] fifo_data_oe,
  input wire logic [7:0] fifo_tx_byte,
  input wire logic fifo_drive,
  output logic [7:0] fifo_rx_byte
);
  // ****************************************
  // configuration store and active selection
  // ****************************************
  logic [3:0] store_a_ff, store_b_ff, aw_ofs_ff, wstrb_ff;
  logic [3:0] sel_ff [2];
  logic store_chg_ff, chg_sleep_ff, load_ff, apply_req, frame_tgl_ff, susp_ff, buspwr_ff;
  logic aw_got_ff, w_got_ff, wr_fire, rd_hit;
  logic [1:0] pin_meta_ff, pin_sync_ff, nxt_out, nxt_oe;
  logic [7:0] data_meta_ff, data_sync_ff;
  logic [31:0] wdata_ff, rd_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_a_ff <= caps_pkg::RST_SEL_A;
      store_b_ff <= caps_pkg::RST_SEL_B;
      store_chg_ff <= caps_pkg::RST_CHG_SLEEP;
    end else if (wr_fire && aw_ofs_ff == caps_pkg::OFS_STORE) begin
      if (wstrb_ff[0]) begin
        store_a_ff <= wdata_ff[caps_pkg::SEL_A_LSB +: 4];
        store_b_ff <= wdata_ff[caps_pkg::SEL_B_LSB +: 4];
      end
      if (wstrb_ff[1]) begin
        store_chg_ff <= wdata_ff[caps_pkg::CHG_SLEEP_BIT];
      end
    end
  end

  assign apply_req = wr_fire && aw_ofs_ff == caps_pkg::OFS_APPLY && wstrb_ff[0]
    && wdata_ff[caps_pkg::APPLY_BIT];

  // held in reset, loaded at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_ff <= 1'b1;
      sel_ff[0] <= caps_pkg::RST_SEL_A;
      sel_ff[1] <= caps_pkg::RST_SEL_B;
      chg_sleep_ff <= caps_pkg::RST_CHG_SLEEP;
    end else begin
      load_ff <= 1'b0;
      if (load_ff || apply_req) begin
        sel_ff[0] <= store_a_ff;
        sel_ff[1] <= store_b_ff;
        chg_sleep_ff <= store_chg_ff;
      end
    end
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      data_meta_ff <= 8'h00;
      data_sync_ff <= 8'h00;
    end else begin
      pin_meta_ff <= aux_pin_in;
      pin_sync_ff <= pin_meta_ff;
      data_meta_ff <= fifo_data_in;
      data_sync_ff <= data_meta_ff;
    end
  end

  // ****************************************
  // device state from the usb engine and the pins
  // ****************************************
  // frame toggle flips per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_tgl_ff <= 1'b0;
    end else if (sof_pulse) begin
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end

  // sense and stay awake inputs
  // with no sense pin, bus power is assumed present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_ff <= 1'b0;
      buspwr_ff <= 1'b0;
    end else begin
      susp_ff <= usb_suspend_req
        && !(sel_ff[0] == caps_pkg::FN_STAY_AWAKE_N && !pin_sync_ff[0])
        && !(sel_ff[1] == caps_pkg::FN_STAY_AWAKE_N && !pin_sync_ff[1]);
      if (sel_ff[0] == caps_pkg::FN_BUS_SENSE) begin
        buspwr_ff <= pin_sync_ff[0];
      end else if (sel_ff[1] == caps_pkg::FN_BUS_SENSE) begin
        buspwr_ff <= pin_sync_ff[1];
      end else begin
        buspwr_ff <= 1'b1;
      end
    end
  end

  assign suspend_active = susp_ff;
  assign bus_power_detect = buspwr_ff;

  // ****************************************
  // per pin function mux
  // ****************************************
  // outputs registered, so every function lags its source by one edge
  for (genvar k = 0; k < 2; k++) begin : g_pin
    always_comb begin
      nxt_out[k] = 1'b0;
      nxt_oe[k] = 1'b1;
      unique case (sel_ff[k])
        caps_pkg::FN_HIZ: nxt_oe[k] = 1'b0;
        caps_pkg::FN_DRIVE_HI: nxt_out[k] = 1'b1;
        caps_pkg::FN_DRIVE_LO: nxt_out[k] = 1'b0;
        caps_pkg::FN_POWER_SW: nxt_oe[k] = usb_configured && !susp_ff;
        caps_pkg::FN_SLEEP_N: nxt_out[k] = !susp_ff || (chg_sleep_ff && charger_port);
        caps_pkg::FN_CLK24: nxt_out[k] = clk_src[0] && !susp_ff;
        caps_pkg::FN_CLK12: nxt_out[k] = clk_src[1] && !susp_ff;
        caps_pkg::FN_CLK6: nxt_out[k] = clk_src[2] && !susp_ff;
        caps_pkg::FN_CHARGER: nxt_out[k] = charger_port;
        caps_pkg::FN_CHARGER_N: nxt_oe[k] = charger_port;
        caps_pkg::FN_WR_STROBE_N: nxt_out[k] = pin_mode_write_strobe_n;
        caps_pkg::FN_RD_STROBE_N: nxt_out[k] = pin_mode_read_strobe_n;
        caps_pkg::FN_FRAME_TGL: nxt_out[k] = frame_tgl_ff;
        caps_pkg::FN_BUS_SENSE, caps_pkg::FN_STAY_AWAKE_N: nxt_oe[k] = 1'b0;
        default: nxt_oe[k] = 1'b0;
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        aux_pin_out[k] <= 1'b0;
        aux_pin_oe[k] <= 1'b0;
      end else begin
        aux_pin_out[k] <= nxt_out[k];
        aux_pin_oe[k] <= nxt_oe[k];
      end
    end
  end

  // ****************************************
  // fifo data port
  // ****************************************
  // eight bit bidirectional data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_data_out <= 8'h00;
      fifo_data_oe <= 8'h00;
      fifo_rx_byte <= 8'h00;
    end else begin
      fifo_data_out <= fifo_tx_byte;
      fifo_data_oe <= {8{fifo_drive}};
      fifo_rx_byte <= data_sync_ff;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid;

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_ofs_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= caps_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got_ff <= 1'b1;
        aw_ofs_ff <= (awaddr[31:4] == 28'h000_0000) ? awaddr[3:0] : 4'hf;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_ofs_ff == caps_pkg::OFS_STORE || aw_ofs_ff == caps_pkg::OFS_APPLY)
          ? caps_pkg::RESP_OKAY : caps_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr[31:4] != 28'h000_0000) begin
      rd_hit = 1'b0;
    end else if (araddr[3:0] == caps_pkg::OFS_STORE) begin
      rd_word[caps_pkg::SEL_A_LSB +: 4] = store_a_ff;
      rd_word[caps_pkg::SEL_B_LSB +: 4] = store_b_ff;
      rd_word[caps_pkg::CHG_SLEEP_BIT] = store_chg_ff;
    end else if (araddr[3:0] == caps_pkg::OFS_STATUS) begin
      rd_word[caps_pkg::SEL_A_LSB +: 4] = sel_ff[0];
      rd_word[caps_pkg::SEL_B_LSB +: 4] = sel_ff[1];
      rd_word[caps_pkg::CHG_SLEEP_BIT] = chg_sleep_ff;
      rd_word[caps_pkg::ST_BUSPWR_BIT] = buspwr_ff;
      rd_word[caps_pkg::ST_SUSP_BIT] = susp_ff;
      rd_word[caps_pkg::ST_FRAME_BIT] = frame_tgl_ff;
    end else if (araddr[3:0] != caps_pkg::OFS_APPLY) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= caps_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? caps_pkg::RESP_OKAY : caps_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hiz_sel(k);
    sel_ff[k] == caps_pkg::FN_HIZ;
  endsequence

  hiz_pin_a: assert property (s_hiz_sel(0) |=> !aux_pin_oe[0])
    else $error("hi-z pin a driven");
  power_sw_od_a: assert property (
    sel_ff[0] == caps_pkg::FN_POWER_SW |=> !aux_pin_out[0]
      && aux_pin_oe[0] == ($past(usb_configured) && !$past(susp_ff)))
    else $error("power switch pin wrong");
  sleep_out_a: assert property (
    sel_ff[0] == caps_pkg::FN_SLEEP_N && susp_ff && !chg_sleep_ff |=> !aux_pin_out[0])
    else $error("sleep pin high in suspend");
  chg_sleep_a: assert property (
    sel_ff[0] == caps_pkg::FN_SLEEP_N && chg_sleep_ff && charger_port |=> aux_pin_out[0])
    else $error("sleep pin low on charger");
  clk_stop_a: assert property (
    susp_ff && sel_ff[0] inside {caps_pkg::FN_CLK24, caps_pkg::FN_CLK12, caps_pkg::FN_CLK6}
      |=> !aux_pin_out[0])
    else $error("clock runs in suspend");
  charger_n_a: assert property (
    sel_ff[0] == caps_pkg::FN_CHARGER_N |=> !aux_pin_out[0]
      && aux_pin_oe[0] == $past(charger_port))
    else $error("inverted charger wrong");
  frame_flip_a: assert property (sof_pulse |=> frame_tgl_ff != $past(frame_tgl_ff))
    else $error("frame toggle missed");
  stay_awake_a: assert property (
    sel_ff[1] == caps_pkg::FN_STAY_AWAKE_N && !pin_sync_ff[1] |=> !susp_ff)
    else $error("suspend despite stay awake");
  sense_in_a: assert property (
    sel_ff[0] == caps_pkg::FN_BUS_SENSE ##1 sel_ff[0] == caps_pkg::FN_BUS_SENSE
      |-> !aux_pin_oe[0] && buspwr_ff == $past(pin_sync_ff[0]))
    else $error("bus sense wrong");
  sel_fixed_a: assert property (
    !load_ff && !apply_req |=> $stable(sel_ff[0]) && $stable(sel_ff[1]))
    else $error("selection changed");
  reset_default_a: assert property (
    $rose(aresetn) |-> sel_ff[1] == caps_pkg::RST_SEL_B)
    else $error("reset default wrong");
endmodule : caps_top

// >>> verification/caps_far_side.sv
// far side model: board pull-ups, an external driver on each aux pin and on the data pins
// assumes oe high means the design drives the pin; a released pin rests high
`timescale 1ns/1ps
module caps_far_side (
  // design pin side
  input wire logic [1:0] aux_pin_out,
  input wire logic [1:0] aux_pin_oe,
  input wire logic [7:0] fifo_data_out,
  input wire logic [7:0] fifo_data_oe,
  output logic [1:0] aux_pin_in,
  output logic [7:0] fifo_data_in,
  // external drivers
  input wire logic [1:0] ext_oe,
  input wire logic [1:0] ext_val,
  input wire logic [7:0] ext_data,
  input wire logic [7:0] ext_data_oe
);
  // ****************
  // pin levels
  // ****************
  // released pin rests on the pull-up
  // outside party drives sense and stay awake
  assign aux_pin_in = (aux_pin_oe & aux_pin_out) | (~aux_pin_oe & ext_oe & ext_val) | (~aux_pin_oe & ~ext_oe);
  // eight data lines, either side drives, pull-up otherwise
  assign fifo_data_in = (fifo_data_oe & fifo_data_out) | (~fifo_data_oe & ext_data_oe & ext_data)
    | (~fifo_data_oe & ~ext_data_oe);
endmodule : caps_far_side

// >>> verification/config_aux_pin_function_select_bench.sv
// self-checking bench for the aux pin selector, registers over axi4-lite
// assumes caps_top and caps_far_side; pin b left high impedance in function tests
`timescale 1ns/1ps
module config_aux_pin_function_select_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, pin_in, pin_out, pin_oe, ext_oe, ext_val;
  logic usb_configured, usb_suspend_req, charger_port, sof_pulse, wr_n, rd_n, bus_pwr, susp, drive, p;
  logic [2:0] clk_src;
  logic [7:0] d_in, d_out, d_oe, tx_byte, rx_byte, ext_d, ext_d_oe;
  int err_count, checked;
  caps_top caps_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .usb_configured(usb_configured), .usb_suspend_req(usb_suspend_req), .charger_port(charger_port),
    .sof_pulse(sof_pulse), .clk_src(clk_src), .pin_mode_write_strobe_n(wr_n), .pin_mode_read_strobe_n(rd_n),
    .bus_power_detect(bus_pwr), .suspend_active(susp), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
    .aux_pin_oe(pin_oe), .fifo_data_in(d_in), .fifo_data_out(d_out), .fifo_data_oe(d_oe),
    .fifo_tx_byte(tx_byte), .fifo_drive(drive), .fifo_rx_byte(rx_byte));
  caps_far_side caps_far_side_inst (.aux_pin_out(pin_out), .aux_pin_oe(pin_oe), .fifo_data_out(d_out),
    .fifo_data_oe(d_oe), .aux_pin_in(pin_in), .fifo_data_in(d_in), .ext_oe(ext_oe), .ext_val(ext_val),
    .ext_data(ext_d), .ext_data_oe(ext_d_oe));
  // ****************
  // helpers
  // ****************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pina(input logic eo, input logic lv);
    chk("pin a oe", {31'h0, eo}, {31'h0, pin_oe[0]});
    chk("pin a level", {31'h0, lv}, {31'h0, pin_in[0]});
  endtask : pina
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask : settle
  // master holds each channel until its own handshake edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) chk("write response wait", 32'h1, 32'h0);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) chk("read data wait", 32'h1, 32'h0);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic cfg(input logic [3:0] a, input logic [3:0] b, input logic chg);
    axi_wr({28'h0, caps_pkg::OFS_STORE}, {23'h0, chg, b, a}, rsp);
    axi_wr({28'h0, caps_pkg::OFS_APPLY}, 32'h0000_0001, rsp);
    settle;
  endtask : cfg
  task automatic status(input logic [8:0] exp);
    axi_rd({28'h0, caps_pkg::OFS_STATUS}, rd_v, rsp);
    chk("status selection", {23'h0, exp}, {23'h0, rd_v[8:0]});
  endtask : status
  // ****************
  // scenarios
  // ****************
  task automatic t_defaults;
    status({caps_pkg::RST_CHG_SLEEP, caps_pkg::RST_SEL_B, caps_pkg::RST_SEL_A});
    chk("pin oe", 32'h0, {30'h0, pin_oe});
    ext_oe <= 2'b11;
    ext_val <= 2'b00;
    usb_suspend_req <= 1'b1;
    settle;
    chk("bus power low", 32'h0, {31'h0, bus_pwr});
    chk("suspend blocked", 32'h0, {31'h0, susp});
    ext_val <= 2'b01;
    ext_oe <= 2'b01;
    settle;
    chk("bus power high", 32'h1, {31'h0, bus_pwr});
    chk("suspend free", 32'h1, {31'h0, susp});
    usb_suspend_req <= 1'b0;
    ext_oe <= 2'b00;
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_regs;
    axi_wr({28'h0, caps_pkg::OFS_STORE}, 32'h0000_0001, rsp);
    status({caps_pkg::RST_CHG_SLEEP, caps_pkg::RST_SEL_B, caps_pkg::RST_SEL_A});
    axi_wr(32'h0000_0010, 32'h0000_0001, rsp);
    chk("unmapped write", {30'h0, caps_pkg::RESP_SLVERR}, {30'h0, rsp});
    axi_rd(32'h0000_0010, rd_v, rsp);
    chk("unmapped read", {30'h0, caps_pkg::RESP_SLVERR}, {30'h0, rsp});
    axi_wr({28'h0, caps_pkg::OFS_APPLY}, 32'h0000_0001, rsp);
    status(9'h001);
    axi_rd({28'h0, caps_pkg::OFS_APPLY}, rd_v, rsp);
    chk("apply read data", 32'h0, rd_v);
    chk("apply read resp", {30'h0, caps_pkg::RESP_OKAY}, {30'h0, rsp});
    $display("test registers done");
  endtask : t_regs
  task automatic t_functions;
    int k;
    for (k = 0; k < 3; k++) begin
      cfg(k[3:0], 4'h0, 1'b0);
      pina(k != 0, k != 2);
    end
    cfg(caps_pkg::FN_POWER_SW, 4'h0, 1'b0);
    pina(1'b0, 1'b1);
    usb_configured <= 1'b1;
    settle;
    pina(1'b1, 1'b0);
    usb_suspend_req <= 1'b1;
    settle;
    pina(1'b0, 1'b1);
    cfg(caps_pkg::FN_SLEEP_N, 4'h0, 1'b0);
    charger_port <= 1'b1;
    settle;
    pina(1'b1, 1'b0);
    cfg(caps_pkg::FN_SLEEP_N, 4'h0, 1'b1);
    pina(1'b1, 1'b1);
    usb_suspend_req <= 1'b0;
    charger_port <= 1'b0;
    settle;
    pina(1'b1, 1'b1);
    for (k = 0; k < 3; k++) begin
      cfg(caps_pkg::FN_CLK24 + k[3:0], 4'h0, 1'b0);
      clk_src <= 3'h1 << k;
      settle;
      pina(1'b1, 1'b1);
      clk_src <= 3'h0;
      usb_suspend_req <= 1'b1;
      settle;
      clk_src <= 3'h1 << k;
      settle;
      pina(1'b1, 1'b0);
      usb_suspend_req <= 1'b0;
    end
    $display("test functions done");
  endtask : t_functions
  task automatic t_signals;
    cfg(caps_pkg::FN_CHARGER, 4'h0, 1'b0);
    charger_port <= 1'b1;
    settle;
    pina(1'b1, 1'b1);
    cfg(caps_pkg::FN_CHARGER_N, 4'h0, 1'b0);
    pina(1'b1, 1'b0);
    charger_port <= 1'b0;
    settle;
    pina(1'b0, 1'b1);
    cfg(caps_pkg::FN_WR_STROBE_N, 4'h0, 1'b0);
    wr_n <= 1'b0;
    settle;
    pina(1'b1, 1'b0);
    cfg(caps_pkg::FN_RD_STROBE_N, 4'h0, 1'b0);
    pina(1'b1, 1'b1);
    rd_n <= 1'b0;
    settle;
    pina(1'b1, 1'b0);
    cfg(caps_pkg::FN_FRAME_TGL, 4'h0, 1'b0);
    p = pin_in[0];
    sof_pulse <= 1'b1;
    @(posedge aclk);
    sof_pulse <= 1'b0;
    settle;
    pina(1'b1, ~p);
    $display("test signals done");
  endtask : t_signals
  task automatic t_swapped;
    cfg(caps_pkg::FN_STAY_AWAKE_N, caps_pkg::FN_BUS_SENSE, 1'b0);
    chk("swapped oe", 32'h0, {30'h0, pin_oe});
    ext_oe <= 2'b11;
    ext_val <= 2'b10;
    usb_suspend_req <= 1'b1;
    settle;
    chk("pin b bus power high", 32'h1, {31'h0, bus_pwr});
    chk("pin a blocks suspend", 32'h0, {31'h0, susp});
    ext_val <= 2'b01;
    settle;
    chk("pin b bus power low", 32'h0, {31'h0, bus_pwr});
    chk("pin a suspend free", 32'h1, {31'h0, susp});
    usb_suspend_req <= 1'b0;
    ext_oe <= 2'b00;
    cfg(caps_pkg::FN_HIZ, caps_pkg::FN_HIZ, 1'b0);
    chk("no sense pin", 32'h1, {31'h0, bus_pwr});
    $display("test swapped inputs done");
  endtask : t_swapped
  task automatic t_fifo_reset;
    tx_byte <= 8'ha5;
    drive <= 1'b1;
    settle;
    chk("data out", 32'h0000_a5ff, {16'h0, d_out, d_oe});
    drive <= 1'b0;
    ext_d <= 8'h5a;
    ext_d_oe <= 8'hff;
    settle;
    chk("data in", 32'h0000_005a, {24'h0, rx_byte});
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("oe in reset", 32'h0, {30'h0, pin_oe});
    aresetn <= 1'b1;
    settle;
    status({caps_pkg::RST_CHG_SLEEP, caps_pkg::RST_SEL_B, caps_pkg::RST_SEL_A});
    $display("test fifo and reset done");
  endtask : t_fifo_reset
  // ****************
  // sequence and watchdog
  // ****************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, usb_configured, usb_suspend_req} = 8'h00;
    {charger_port, sof_pulse, drive, clk_src, ext_oe, ext_val} = 10'h000;
    {awaddr, wdata, araddr} = 96'h0;
    {tx_byte, ext_d, ext_d_oe} = 24'h00_0000;
    wstrb = 4'hf;
    wr_n = 1'b1;
    rd_n = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    t_defaults;
    t_regs;
    t_functions;
    t_signals;
    t_swapped;
    t_fifo_reset;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    chk("run finished", 32'h1, 32'h0);
    end_sim;
  end
endmodule : config_aux_pin_function_select_bench
